// ===== fcm_mode_ctrl.sv
// Read mode and automatic operation control of the flash command sequencer
// Overview of operation
// - Accepted command runs internally without host
// - Automatic state entered only by a sequence begun in read or identifier read mode
// - No array reads or fetches while busy
// - Only completion or hardware reset exits automatic operation
// - Read mode after reset and normal completion
// - After failure, read/reset or hardware reset
// - Identifier read holds until read/reset or a first unlock write
// - Single 0xF0 write returns read mode, except while busy (page load or automatic operation)
// - Three-cycle read/reset cancels partial command
// - Deviating write abandons command to read
// - CPU reset ends operation, restores read
// - Watchdog reset restores read like reset pin, but leaves operation timer running
// - Array readable after reset for vector fetch
// - Ready/busy flag at status bit 0
`timescale 1ns/1ns
`default_nettype none
`include "fcm_cfg.svh"
module fcm_mode_ctrl #(
   parameter logic [31:0] PROG_CYCLES  = `FCM_PROG_CYCLES,
   parameter logic [31:0] ERASE_CYCLES = `FCM_ERASE_CYCLES,
   parameter int          PAGE_WORDS   = `FCM_PAGE_WORDS
) (
   input  wire logic             clk,                   // System clock, 125 MHz
   input  wire logic             reset,                 // CPU reset from pin, async
   input  wire logic             ce,                    // Clock enable, freezes state
   input  wire logic             wdt_reset,             // Watchdog overflow reset
   input  wire logic             wr_valid,              // Bus write cycle to flash
   input  wire logic             wr_word,               // Write is 32 bits wide
   input  wire logic [31:0]      wr_addr,               // Write address
   input  wire logic [31:0]      wr_data,               // Write data
   input  wire logic             array_fail,            // Array operation failed
   output logic                  ready_busy_flag,       // 1 ready, 0 busy
   output logic [31:0]           flash_ctrl_status_reg, // Status register value
   output logic                  array_read_ok,         // Reads and fetches served
   output logic                  identifier_read_cmd_sel,           // Reads return identifier
   output logic                  op_start,              // Operation start pulse
   output fcm_pkg::fcm_op_t      op_kind,               // Operation kind
   output logic [31:0]           op_addr,               // Block or page address
   output logic                  prog_wr_valid,         // Page word to array
   output logic [31:0]           prog_wr_addr,          // Page word address
   output logic [31:0]           prog_wr_data,          // Page word data
   output logic                  cmd_abort              // Sequence abandoned pulse
);
   import fcm_pkg::*;

   localparam int CW = $clog2(PAGE_WORDS + 1);

   fcm_op_if op ();

   fcm_state_t     st_r;
   fcm_state_t     st_nxt;
   logic [CW-1:0]  cnt_r;
   logic [CW-1:0]  cnt_nxt;
   logic           erase_r;
   logic           erase_nxt;
   fcm_op_t        kind_r;
   fcm_op_t        kind_nxt;
   logic [31:0]    addr_r;
   logic [31:0]    addr_nxt;
   logic           start_r;
   logic           start_nxt;
   logic           abort_r;
   logic           abort_nxt;
   logic           pw_r;
   logic           pw_nxt;
   logic [31:0]    pa_r;
   logic [31:0]    pa_nxt;
   logic [31:0]    pd_r;
   logic [31:0]    pd_nxt;
   logic           unlock1;
   logic           unlock2;
   logic           at_cmd;
   logic           read_rst;

   // Narrow writes never match a token, so they break a sequence
   fcm_cmd_decode u_dec (
      .addr     (wr_addr),
      .data     (wr_data),
      .word     (wr_word),
      .unlock1  (unlock1),
      .unlock2  (unlock2),
      .at_cmd   (at_cmd),
      .read_rst (read_rst)
   );

   // Carries out the accepted operation with no further bus traffic
   fcm_op_timer #(
      .PROG_CYCLES  (PROG_CYCLES),
      .ERASE_CYCLES (ERASE_CYCLES)
   ) u_tmr (
      .clk        (clk),
      .reset      (reset),
      .ce         (ce),
      .array_fail (array_fail),
      .op         (op.timer)
   );

   assign op.start = start_r;
   assign op.kind  = kind_r;

   // Command sequence and mode state machine
   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      erase_nxt = erase_r;
      kind_nxt  = kind_r;
      addr_nxt  = addr_r;
      start_nxt = 1'b0;
      abort_nxt = 1'b0;
      pw_nxt    = 1'b0;
      pa_nxt    = pa_r;
      pd_nxt    = pd_r;
      unique case (st_r)
         FCM_S_READ: begin
            if (wr_valid && unlock1) begin
               st_nxt    = FCM_S_CMD1;
               erase_nxt = 1'b0;
            end
         end
         FCM_S_CMD1: begin
            if (wr_valid) begin
               if (unlock2) begin
                  st_nxt = FCM_S_CMD2;
               end else begin
                  st_nxt    = FCM_S_READ;
                  abort_nxt = !read_rst;
               end
            end
         end
         FCM_S_CMD2: begin
            if (wr_valid) begin
               st_nxt = FCM_S_READ;
               if (at_cmd && wr_data == `FCM_DATA_PROG) begin
                  st_nxt   = FCM_S_PROG_LOAD;
                  cnt_nxt  = '0;
                  kind_nxt = FCM_OP_PROG;
               end else if (at_cmd && wr_data == `FCM_DATA_IDENTIFIER_READ_CMD) begin
                  st_nxt = FCM_S_ID;
               end else if (at_cmd && wr_data == `FCM_DATA_ERASE) begin
                  st_nxt = FCM_S_ERA3;
               end else if (!read_rst) begin
                  abort_nxt = 1'b1;
               end
            end
         end
         FCM_S_ERA3: begin
            if (wr_valid) begin
               st_nxt    = unlock1 ? FCM_S_ERA4 : FCM_S_READ;
               abort_nxt = !unlock1 && !read_rst;
            end
         end
         FCM_S_ERA4: begin
            if (wr_valid) begin
               st_nxt    = unlock2 ? FCM_S_ERA5 : FCM_S_READ;
               abort_nxt = !unlock2 && !read_rst;
            end
         end
         FCM_S_ERA5: begin
            if (wr_valid) begin
               st_nxt = FCM_S_READ;
               if (at_cmd && wr_data == `FCM_DATA_CHIP_ERA) begin
                  st_nxt    = FCM_S_AUTO;
                  kind_nxt  = FCM_OP_CHIP_ERASE;
                  start_nxt = 1'b1;
               end else if (wr_word && wr_data == `FCM_DATA_BLK_ERA) begin
                  st_nxt    = FCM_S_AUTO;
                  kind_nxt  = FCM_OP_BLK_ERASE;
                  addr_nxt  = wr_addr;
                  start_nxt = 1'b1;
               end else if (!read_rst) begin
                  abort_nxt = 1'b1;
               end
            end
         end
         FCM_S_PROG_LOAD: begin
            // Page words are taken as data; a software reset has no effect here
            if (wr_valid && wr_word) begin
               pw_nxt  = 1'b1;
               pa_nxt  = wr_addr;
               pd_nxt  = wr_data;
               cnt_nxt = cnt_r + CW'(1);
               if (cnt_r == '0) begin
                  addr_nxt = wr_addr;
               end
               if (cnt_r == CW'(PAGE_WORDS - 1)) begin
                  st_nxt    = FCM_S_AUTO;
                  start_nxt = 1'b1;
               end
            end
         end
         FCM_S_AUTO: begin
            // Writes are ignored; only completion or reset leaves this state
            if (op.done) begin
               st_nxt = FCM_S_READ;
            end else if (op.fail) begin
               st_nxt = FCM_S_LOCK;
            end
         end
         FCM_S_ID: begin
            if (wr_valid && read_rst) begin
               st_nxt = FCM_S_READ;
            end else if (wr_valid && unlock1) begin
               st_nxt = FCM_S_CMD1;
            end
         end
         FCM_S_LOCK: begin
            if (wr_valid && read_rst) begin
               st_nxt = FCM_S_READ;
            end
         end
      endcase
   end

   // State registers; any CPU reset, pin or watchdog, restores read mode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r    <= FCM_S_READ;
         cnt_r   <= '0;
         erase_r <= 1'b0;
         kind_r  <= FCM_OP_PROG;
         addr_r  <= 32'h0000_0000;
         start_r <= 1'b0;
         abort_r <= 1'b0;
         pw_r    <= 1'b0;
         pa_r    <= 32'h0000_0000;
         pd_r    <= 32'h0000_0000;
      end else if (wdt_reset) begin
         st_r    <= FCM_S_READ;
         cnt_r   <= '0;
         start_r <= 1'b0;
         abort_r <= 1'b0;
         pw_r    <= 1'b0;
      end else if (ce) begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         erase_r <= erase_nxt;
         kind_r  <= kind_nxt;
         addr_r  <= addr_nxt;
         start_r <= start_nxt;
         abort_r <= abort_nxt;
         pw_r    <= pw_nxt;
         pa_r    <= pa_nxt;
         pd_r    <= pd_nxt;
      end else begin
         start_r <= 1'b0;
         abort_r <= 1'b0;
         pw_r    <= 1'b0;
      end
   end

   // Mode outputs: busy from the third program cycle or erase start onward
   always_comb begin
      ready_busy_flag = !(st_r == FCM_S_PROG_LOAD || st_r == FCM_S_AUTO);
      flash_ctrl_status_reg = `FCM_STATUS_RST & 32'h0000_0000;
      flash_ctrl_status_reg[`FCM_RDY_BIT] = ready_busy_flag;
      array_read_ok = ready_busy_flag && st_r != FCM_S_ID
                      && st_r != FCM_S_LOCK;
      identifier_read_cmd_sel   = st_r == FCM_S_ID;
   end

   assign op_start      = start_r;
   assign op_kind       = kind_r;
   assign op_addr       = addr_r;
   assign prog_wr_valid = pw_r;
   assign prog_wr_addr  = pa_r;
   assign prog_wr_data  = pd_r;
   assign cmd_abort     = abort_r;
endmodule
`default_nettype wire

// ===== fcm_cfg.svh
// Constants of the flash command mode control block
`ifndef FCM_CFG_SVH
`define FCM_CFG_SVH

// Command cycle addresses, compared on the low address half
`define FCM_ADDR_LO_W      16
`define FCM_UNLOCK_ADDR1   16'h5400
`define FCM_UNLOCK_ADDR2   16'haa00
`define FCM_CMD_ADDR       16'h5400

// Command cycle data codes
`define FCM_DATA_UNLOCK1   32'h0000_00aa
`define FCM_DATA_UNLOCK2   32'h0000_0055
`define FCM_DATA_READ_RST  32'h0000_00f0
`define FCM_DATA_PROG      32'h0000_00a0
`define FCM_DATA_IDENTIFIER_READ_CMD   32'h0000_0090
`define FCM_DATA_ERASE     32'h0000_0080
`define FCM_DATA_CHIP_ERA  32'h0000_0010
`define FCM_DATA_BLK_ERA   32'h0000_0030

// Status register layout
`define FCM_RDY_BIT        0
`define FCM_STATUS_RST     32'h0000_0001

// Default operation lengths in clock cycles and page size in words
`define FCM_PROG_CYCLES    32'd5000
`define FCM_ERASE_CYCLES   32'd20000
`define FCM_PAGE_WORDS     128

`endif

// ===== fcm_pkg.sv
// Types shared by the flash command mode control modules
package fcm_pkg;
   typedef enum logic [1:0] {
      FCM_OP_PROG,
      FCM_OP_CHIP_ERASE,
      FCM_OP_BLK_ERASE
   } fcm_op_t;

   typedef enum logic [3:0] {
      FCM_S_READ,
      FCM_S_CMD1,
      FCM_S_CMD2,
      FCM_S_ERA3,
      FCM_S_ERA4,
      FCM_S_ERA5,
      FCM_S_PROG_LOAD,
      FCM_S_AUTO,
      FCM_S_ID,
      FCM_S_LOCK
   } fcm_state_t;
endpackage

// ===== fcm_op_if.sv
// Start and completion signals between sequencer and operation timer
`timescale 1ns/1ns
`default_nettype none
interface fcm_op_if;
   import fcm_pkg::*;
   logic    start;   // One-cycle start of an automatic operation
   fcm_op_t kind;    // Operation kind, valid with start
   logic    done;    // One-cycle normal completion
   logic    fail;    // One-cycle abnormal completion

   modport seq   (output start, output kind, input done, input fail);
   modport timer (input start, input kind, output done, output fail);
endinterface
`default_nettype wire

// ===== fcm_cmd_decode.sv
// Classifies one bus write cycle against the command tokens
`timescale 1ns/1ns
`default_nettype none
`include "fcm_cfg.svh"
module fcm_cmd_decode (
   input  wire logic [31:0] addr,       // Write address
   input  wire logic [31:0] data,       // Write data
   input  wire logic        word,       // Write is a full 32-bit transfer
   output logic             unlock1,    // First unlock cycle
   output logic             unlock2,    // Second unlock cycle
   output logic             at_cmd,     // Address of the command cycle
   output logic             read_rst    // Data is the read/reset code
);
   logic [`FCM_ADDR_LO_W-1:0] lo;

   // Low address half selects the command cycle; narrow writes match nothing
   always_comb begin
      lo       = addr[`FCM_ADDR_LO_W-1:0];
      unlock1  = word && lo == `FCM_UNLOCK_ADDR1 && data == `FCM_DATA_UNLOCK1;
      unlock2  = word && lo == `FCM_UNLOCK_ADDR2 && data == `FCM_DATA_UNLOCK2;
      at_cmd   = word && lo == `FCM_CMD_ADDR;
      read_rst = word && data == `FCM_DATA_READ_RST;
   end
endmodule
`default_nettype wire

// ===== fcm_op_timer.sv
// Internal timer that carries out an automatic operation on its own
`timescale 1ns/1ns
`default_nettype none
`include "fcm_cfg.svh"
module fcm_op_timer #(
   parameter logic [31:0] PROG_CYCLES  = `FCM_PROG_CYCLES,
   parameter logic [31:0] ERASE_CYCLES = `FCM_ERASE_CYCLES
) (
   input  wire logic clk,         // System clock
   input  wire logic reset,       // CPU reset, async, active high
   input  wire logic ce,          // Clock enable
   input  wire logic array_fail,  // Array reports a failed operation
   fcm_op_if.timer   op           // Start and completion
);
   import fcm_pkg::*;
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic        run_r;
   logic        run_nxt;
   logic        done_nxt;
   logic        fail_nxt;
   logic        done_r;
   logic        fail_r;

   // Load on start, count down, finish normally or on array failure
   always_comb begin
      cnt_nxt  = cnt_r;
      run_nxt  = run_r;
      done_nxt = 1'b0;
      fail_nxt = 1'b0;
      if (op.start) begin
         run_nxt = 1'b1;
         cnt_nxt = (op.kind == FCM_OP_PROG) ? PROG_CYCLES : ERASE_CYCLES;
      end else if (run_r) begin
         if (array_fail) begin
            run_nxt  = 1'b0;
            fail_nxt = 1'b1;
         end else if (cnt_r <= 32'd1) begin
            run_nxt  = 1'b0;
            done_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - 32'd1;
         end
      end
   end

   // State registers, frozen while the clock enable is low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r  <= 32'h0000_0000;
         run_r  <= 1'b0;
         done_r <= 1'b0;
         fail_r <= 1'b0;
      end else if (ce) begin
         cnt_r  <= cnt_nxt;
         run_r  <= run_nxt;
         done_r <= done_nxt;
         fail_r <= fail_nxt;
      end else begin
         done_r <= 1'b0;
         fail_r <= 1'b0;
      end
   end

   assign op.done = done_r;
   assign op.fail = fail_r;
endmodule
`default_nettype wire

// ===== fcm_mode_ctrl_props.sv
// Property checker for the flash command mode control block
`timescale 1ns/1ns
`default_nettype none
module fcm_mode_ctrl_props
   import fcm_pkg::*;
(
   input wire logic             clk,                   // Clock
   input wire logic             reset,                 // Reset
   input wire logic             ce,                    // Enable
   input wire logic             wdt_reset,             // Watchdog reset
   input wire logic             wr_valid,              // Write strobe
   input wire logic             wr_word,               // Word write
   input wire logic [31:0]      wr_addr,               // Address
   input wire logic [31:0]      wr_data,               // Data
   input wire logic             array_fail,            // Array failure
   input wire logic             ready_busy_flag,       // Ready flag
   input wire logic [31:0]      flash_ctrl_status_reg, // Status
   input wire logic             array_read_ok,         // Reads served
   input wire logic             identifier_read_cmd_sel,           // Identifier read
   input wire logic             op_start,              // Start pulse
   input wire fcm_pkg::fcm_op_t op_kind,               // Kind
   input wire logic [31:0]      op_addr,               // Op address
   input wire logic             prog_wr_valid,         // Page word
   input wire logic [31:0]      prog_wr_addr,          // Page address
   input wire logic [31:0]      prog_wr_data,          // Page data
   input wire logic             cmd_abort              // Abort pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Mode relations between bus writes and outputs
   stat_bit_a: assert property (flash_ctrl_status_reg == {31'h0, ready_busy_flag})
      else $error("status word differs from ready flag");
   busy_noread_a: assert property (!ready_busy_flag |-> !array_read_ok)
      else $error("array served while busy");
   busy_entry_a: assert property ($fell(ready_busy_flag) |-> $past(wr_valid && wr_word && ce))
      else $error("busy entered without a write");
   rst_read_a: assert property ($fell(reset) |-> ready_busy_flag && array_read_ok && !identifier_read_cmd_sel)
      else $error("not in read mode after reset");
   wdt_read_a: assert property (wdt_reset |=> ready_busy_flag && array_read_ok && !identifier_read_cmd_sel)
      else $error("watchdog reset left read mode off");
   f0_read_a: assert property (ce && wr_valid && wr_word && wr_data == 32'h0000_00f0
      && ready_busy_flag |=> array_read_ok && !identifier_read_cmd_sel)
      else $error("single reset write did not restore read");
   abort_read_a: assert property (cmd_abort |-> ready_busy_flag && !identifier_read_cmd_sel && $past(wr_valid && ce))
      else $error("abort without a write or not ready");
   id_hold_a: assert property (identifier_read_cmd_sel && !wr_valid && !wdt_reset |=> identifier_read_cmd_sel)
      else $error("identifier read left by itself");
   start_pulse_a: assert property (op_start |-> !ready_busy_flag ##1 !op_start)
      else $error("start pulse wrong");
   page_word_a: assert property (prog_wr_valid |-> $past(wr_valid && wr_word && ce))
      else $error("page word without a word write");
endmodule
bind fcm_mode_ctrl fcm_mode_ctrl_props u_fcm_mode_ctrl_props (.clk, .reset, .ce, .wdt_reset,
   .wr_valid, .wr_word, .wr_addr, .wr_data, .array_fail, .ready_busy_flag,
   .flash_ctrl_status_reg, .array_read_ok, .identifier_read_cmd_sel, .op_start, .op_kind, .op_addr,
   .prog_wr_valid, .prog_wr_addr, .prog_wr_data, .cmd_abort);
`default_nettype wire

// ===== fcm_cpu_model.sv
// Behavioural CPU core that issues flash bus write cycles
`timescale 1ns/1ns
`default_nettype none
module fcm_cpu_model (
   input  wire logic        clk,             // Clock
   input  wire logic        ready_busy_flag, // Flash ready flag
   output var logic         wr_valid,        // Write strobe
   output var logic         wr_word,         // Word write
   output var logic  [31:0] wr_addr,         // Address
   output var logic  [31:0] wr_data          // Data
);
   int wait_n;
   // Bus idle at time zero
   initial begin
      wr_valid = 1'b0;
      wr_word  = 1'b0;
      wr_addr  = 32'h0;
      wr_data  = 32'h0;
   end
   // One write, taken at the next rising edge
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic w);
      @(posedge clk);
      #1;
      wr_valid = 1'b1;
      wr_word  = w;
      wr_addr  = a;
      wr_data  = d;
   endtask
   // Release; released lines show inverted values
   task automatic idle();
      @(posedge clk);
      #1;
      wr_valid = 1'b0;
      wr_addr  = ~wr_addr;
      wr_data  = ~wr_data;
   endtask
   // Opening write waits for ready; no reads or interrupts meanwhile
   task automatic first(input logic [31:0] a, input logic [31:0] d);
      wait_n = 0;
      while (ready_busy_flag !== 1'b1 && wait_n < 200) begin
         @(posedge clk);
         wait_n++;
      end
      wr(a, d, 1'b1);
   endtask
endmodule
`default_nettype wire

// ===== test_fcm_mode_ctrl.sv
// Self-checking testbench of the flash command mode control block
`timescale 1ns/1ns
`default_nettype none
`include "fcm_cfg.svh"
module test_fcm_mode_ctrl;
   import fcm_pkg::*;
   localparam logic [31:0] A1 = {16'h0, `FCM_UNLOCK_ADDR1};
   localparam logic [31:0] A2 = {16'h0, `FCM_UNLOCK_ADDR2};
   localparam logic [31:0] F0 = `FCM_DATA_READ_RST;
   logic        clk, reset, ce, wdt_reset, array_fail;
   logic        wr_valid, wr_word, ready_busy_flag, array_read_ok, identifier_read_cmd_sel;
   logic        op_start, prog_wr_valid, cmd_abort;
   logic [31:0] wr_addr, wr_data, flash_ctrl_status_reg, op_addr, prog_wr_addr, prog_wr_data;
   fcm_op_t     op_kind;
   int          error_cnt, samples_checked;
   fcm_mode_ctrl #(.PROG_CYCLES(32'd10), .ERASE_CYCLES(32'd20), .PAGE_WORDS(4)) u_fcm_mode_ctrl (
      .clk, .reset, .ce, .wdt_reset, .wr_valid, .wr_word, .wr_addr, .wr_data, .array_fail,
      .ready_busy_flag, .flash_ctrl_status_reg, .array_read_ok, .identifier_read_cmd_sel, .op_start,
      .op_kind, .op_addr, .prog_wr_valid, .prog_wr_addr, .prog_wr_data, .cmd_abort);
   fcm_cpu_model u_fcm_cpu_model (.clk, .ready_busy_flag, .wr_valid, .wr_word, .wr_addr, .wr_data);
   // Clock of 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded wait for start pulse (sel) or ready flag level
   task automatic wait_on(input logic sel, input logic v);
      int n;
      n = 0;
      while ((sel ? op_start : ready_busy_flag) !== v && n < 100) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(sel ? op_start : ready_busy_flag, v);
   endtask
   // Unlock pair, then a command code
   task automatic cmd(input logic [31:0] d);
      u_fcm_cpu_model.first(A1, `FCM_DATA_UNLOCK1);
      u_fcm_cpu_model.wr(A2, `FCM_DATA_UNLOCK2, 1'b1);
      u_fcm_cpu_model.wr(A1, d, 1'b1);
   endtask
   // Six-cycle erase up to its start pulse
   task automatic erase(input logic [31:0] d);
      cmd(`FCM_DATA_ERASE);
      cmd(d);
      u_fcm_cpu_model.idle();
      wait_on(1'b1, 1'b1);
   endtask
   task automatic t_prog();
      cmd(`FCM_DATA_PROG);
      u_fcm_cpu_model.idle();
      chk(ready_busy_flag, 1'b0);
      chk(array_read_ok, 1'b0);
      for (int i = 0; i < 4; i++) begin
         u_fcm_cpu_model.wr(32'h1000 + 4 * i, 32'hc0de_0000 + i, 1'b1);
         u_fcm_cpu_model.idle();
         chk(prog_wr_data, 32'hc0de_0000 + i);
         chk(prog_wr_addr, 32'h1000 + 4 * i);
      end
      wait_on(1'b1, 1'b1);
      chk(op_kind, FCM_OP_PROG);
      chk(op_addr, 32'h1000);
      u_fcm_cpu_model.wr(A1, F0, 1'b1);
      u_fcm_cpu_model.idle();
      chk(ready_busy_flag, 1'b0);
      wait_on(1'b0, 1'b1);
      chk(array_read_ok, 1'b1);
      $display("program test done");
   endtask
   task automatic t_erase();
      erase(`FCM_DATA_CHIP_ERA);
      chk(op_kind, FCM_OP_CHIP_ERASE);
      wait_on(1'b0, 1'b1);
      erase(`FCM_DATA_BLK_ERA);
      chk(op_kind, FCM_OP_BLK_ERASE);
      chk(op_addr, A1);
      wait_on(1'b0, 1'b1);
      $display("erase test done");
   endtask
   task automatic t_id();
      cmd(`FCM_DATA_IDENTIFIER_READ_CMD);
      u_fcm_cpu_model.wr(A2, 32'h12, 1'b1);
      u_fcm_cpu_model.idle();
      chk(identifier_read_cmd_sel, 1'b1);
      u_fcm_cpu_model.wr(32'h7770, F0, 1'b1);
      u_fcm_cpu_model.idle();
      chk(identifier_read_cmd_sel, 1'b0);
      chk(array_read_ok, 1'b1);
      $display("identifier test done");
   endtask
   task automatic t_abort();
      u_fcm_cpu_model.first(A1, `FCM_DATA_UNLOCK1);
      u_fcm_cpu_model.wr(A1, 32'h77, 1'b1);
      u_fcm_cpu_model.idle();
      chk(cmd_abort, 1'b1);
      cmd(F0);
      u_fcm_cpu_model.idle();
      chk(cmd_abort, 1'b0);
      chk(array_read_ok, 1'b1);
      u_fcm_cpu_model.wr(A1, `FCM_DATA_UNLOCK1, 1'b0);
      u_fcm_cpu_model.wr(A2, `FCM_DATA_UNLOCK2, 1'b1);
      u_fcm_cpu_model.wr(A1, `FCM_DATA_PROG, 1'b1);
      u_fcm_cpu_model.idle();
      chk(ready_busy_flag, 1'b1);
      $display("abort test done");
   endtask
   task automatic t_fail();
      erase(`FCM_DATA_CHIP_ERA);
      array_fail = 1'b1;
      wait_on(1'b0, 1'b1);
      array_fail = 1'b0;
      u_fcm_cpu_model.wr(A1, `FCM_DATA_UNLOCK1, 1'b1);
      u_fcm_cpu_model.idle();
      chk(array_read_ok, 1'b0);
      u_fcm_cpu_model.wr(A2, F0, 1'b1);
      u_fcm_cpu_model.idle();
      chk(array_read_ok, 1'b1);
      $display("failure test done");
   endtask
   // Reset in mid-operation from watchdog then pin, and the erase repeated
   task automatic t_hw();
      for (int s = 0; s < 2; s++) begin
         erase(`FCM_DATA_CHIP_ERA);
         if (s == 0) wdt_reset = 1'b1;
         else reset = 1'b1;
         @(posedge clk);
         #1;
         wdt_reset = 1'b0;
         reset = 1'b0;
         chk(ready_busy_flag, 1'b1);
         chk(array_read_ok, 1'b1);
         erase(`FCM_DATA_CHIP_ERA);
         wait_on(1'b0, 1'b1);
      end
      $display("hardware reset test done");
   endtask
   // Verdict and end of run
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      #100000;
      error_cnt++;
      results();
   end
   // Main sequence
   initial begin
      {reset, ce, wdt_reset, array_fail} = 4'h c;
      error_cnt = 0;
      samples_checked = 0;
      repeat (16) @(posedge clk);
      #1;
      reset = 1'b0;
      chk(flash_ctrl_status_reg, 32'h1);
      chk(array_read_ok, 1'b1);
      t_prog();
      t_erase();
      t_id();
      t_abort();
      t_fail();
      t_hw();
      results();
   end
endmodule
`default_nettype wire
